// File: rtl/urx_pkg.sv
// constants, register map and carrier types of the receive-side serial port block
// assumes a single 100 MHz clock and byte addresses on a 32-bit register bus
//
// Behaviour
// [RQ1] break completes as framing error with zero data
// [RQ2] after framing error wait for high line
// [RQ3] idle flag rises during break before stop
// [RQ4] idle low from start to stop sample
// [RQ5] interrupt on word transfer or overrun when enabled; outside address detect the code also needs the held count to reach trig_level for a word transfer
// [RQ6] four held bytes; fifth completing sets overrun
// [RQ7] overrun clears by status then data read
// [RQ8] noise flag rises with data-available, no interrupt
// [RQ9] noise clears by status then data read
// [RQ10] low stop bit sets stored framing error
// [RQ11] parity mismatch sets stored parity error
// [RQ12] software reads error flags before data
// [RQ13] interrupt request is active-low pulse, six sources; the code has five: word transfer, overrun, tx empty, tx idle, wake
// [RQ14] tx sources own enables, rx share one
// [RQ15] status flags read-only to software writes
// [RQ16] address detect interrupts only on high MSB
// [RQ17] software clears parity enable with address detect
// [RQ18] clock stop pauses reception, registers keep contents
// [RQ19] software finishes transfers before idle or sleep
// [RQ20] falling receive pin wakes while clock off
// [RQ21] ignore pin during recovery, deliver wake later
// [RQ22] 16x oversampling, three-sample majority vote
// [RQ23] error flags update with the buffer transfer
package urx_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] REG_DATA = 5'h08;
  localparam logic [ADDR_W-1:0] REG_COUNT = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_BAUD = 5'h10;
  localparam int WORD_W = 9;
  localparam int BAUD_W = 16;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h0000;
  // oversampling phase: three votes around the bit centre
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_NINE = 4'h9;
  typedef enum logic [1:0] {PAR_EVEN = 2'h0, PAR_ODD = 2'h1, PAR_MARK = 2'h2, PAR_SPACE = 2'h3} urx_par_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_START = 3'h1, ST_DATA = 3'h3, ST_STOP1 = 3'h2, ST_STOP2 = 3'h6, ST_WAITHI = 3'h4
  } urx_state_t;
  typedef struct packed {
    logic [1:0] trig_level;
    logic tx_idle_ie;
    logic tx_empty_ie;
    logic rx_wake_enable;
    logic address_detect_enable;
    logic rx_interrupt_enable;
    logic two_stop;
    urx_par_t parity_type;
    logic parity_enable;
    logic nine_bit_select;
    logic receiver_enable;
    logic port_enable;
  } urx_ctrl_t;
  localparam int CTRL_W = $bits(urx_ctrl_t);
  typedef struct packed {
    logic tx_idle;
    logic tx_empty;
    logic overrun_flag;
    logic noise_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic receiver_idle_flag;
    logic rx_data_available_flag;
  } urx_status_t;
  typedef struct packed {
    logic pe;
    logic fe;
    logic [WORD_W-1:0] word;
  } urx_entry_t;
  localparam int ENTRY_W = $bits(urx_entry_t);
endpackage

// File: rtl/urx_sync.sv
// two-stage synchroniser for asynchronous pin levels
// assumes the input may change at any time relative to clk_i
`timescale 1ns/1ps
module urx_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // level in and out
  input wire logic [W-1:0] d_i,
  input wire logic [W-1:0] rst_val_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } urx_sync_st_t;
  urx_sync_st_t s;
  urx_sync_st_t next_s;

  initial begin
    if (W < 1) $error("width must be at least one");
  end

  // first stage is read only by the second
  always_comb begin
    next_s.meta = d_i;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.meta <= rst_val_i;
      s.sync <= rst_val_i;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.sync;
endmodule

// File: rtl/urx_fifo.sv
// small receive buffer held in flip-flops, indexed read and write pointers
// assumes push is only given when not full or when popping in the same cycle
`timescale 1ns/1ps
module urx_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 4,
  localparam int PW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write side
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  // read side
  input wire logic pop_i,
  output logic [W-1:0] head_o,
  output logic [CW-1:0] count_o,
  output logic full_o,
  output logic empty_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } urx_fifo_st_t;
  urx_fifo_st_t s;
  urx_fifo_st_t next_s;
  logic do_pop;
  logic do_push;

  initial begin
    if (DEPTH < 2) $error("depth must be at least two");
  end

  // pointers wrap at the last index
  always_comb begin
    next_s = s;
    do_pop = pop_i && (s.cnt != '0);
    do_push = push_i && ((s.cnt != CW'(DEPTH)) || do_pop);
    if (do_push) begin
      next_s.mem[s.wp] = data_i;
      next_s.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (do_pop) begin
      next_s.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign head_o = s.mem[s.rp];
  assign count_o = s.cnt;
  assign full_o = (s.cnt == CW'(DEPTH));
  assign empty_o = (s.cnt == '0);
endmodule

// File: rtl/urx_top.sv
// receive side of an asynchronous serial port: oversampled recovery, error flags,
// four-deep buffer, interrupt pulse and pin wake-up, registers over Avalon-MM
// assumes fh_off_i and the transmitter levels come from logic on clk_i
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module urx_top
  import urx_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int RECOVER_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [urx_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [urx_pkg::DATA_W-1:0] avs_writedata_i,
  output logic [urx_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // serial line
  input wire logic serial_receive_pin_i,
  // system state and enables
  input wire logic fh_off_i,
  input wire logic global_interrupt_enable_i,
  input wire logic multifunction_interrupt_enable_i,
  input wire logic port_interrupt_enable_i,
  // transmitter status levels
  input wire logic tx_buffer_empty_i,
  input wire logic tx_idle_i,
  // requests
  output logic irq_n_o,
  output logic wake_o
);
  import urx_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam int RW = $clog2(RECOVER_CYCLES + 1);

  typedef struct packed {
    urx_state_t st;
    logic [3:0] os;
    logic [BAUD_W-1:0] div;
    logic [2:0] smp;
    logic [3:0] nbit;
    logic [WORD_W-1:0] sh;
    logic nz_frame;
    logic noise;
    logic ovr;
    logic arm;
    urx_ctrl_t ctrl;
    logic [BAUD_W-1:0] baud;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic irq_n;
    logic wake;
    logic wpend;
    logic rx_prev;
    logic off_prev;
    logic [1:0] tx_prev;
    logic [RW-1:0] rec;
  } urx_st_t;

  urx_st_t s;
  urx_st_t next_s;
  logic rx;
  logic push;
  logic pop;
  urx_entry_t entry;
  urx_entry_t head;
  logic [CW-1:0] count;
  logic full;
  logic empty;

  initial begin
    if (FIFO_DEPTH < 2) $error("buffer depth must be at least two");
    if (RECOVER_CYCLES < 1) $error("recovery must last at least one cycle");
  end

  // receive pin passes two flip-flops before use
  urx_sync #(
    .W(1)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(serial_receive_pin_i),
    .rst_val_i(1'b1),
    .q_o(rx)
  );

  // receive buffer: words with their stored error flags
  urx_fifo #(
    .W(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .data_i(entry),
    .pop_i(pop),
    .head_o(head),
    .count_o(count),
    .full_o(full),
    .empty_o(empty)
  );

  // majority of three samples
  function automatic logic vote3(input logic [2:0] v);
    vote3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // next state of the whole block
  always_comb begin
    logic running;
    logic tick;
    logic [2:0] votes;
    logic bitv;
    logic mid;
    logic fin;
    logic fe_now;
    logic [WORD_W-1:0] w;
    logic msb;
    logic ones;
    logic pe;
    logic space;
    logic rx_evt;
    logic ovr_evt;
    logic tx_evt;
    logic wake_irq;
    logic [1:0] tx_lvl;
    urx_status_t status;
    next_s = s;
    running = 1'b0;
    tick = 1'b0;
    votes = 3'h0;
    bitv = 1'b0;
    mid = 1'b0;
    fin = 1'b0;
    fe_now = 1'b0;
    w = '0;
    msb = 1'b0;
    ones = 1'b0;
    pe = 1'b0;
    space = 1'b0;
    rx_evt = 1'b0;
    ovr_evt = 1'b0;
    tx_evt = 1'b0;
    wake_irq = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    entry = '0;
    status = '0;
    next_s.irq_n = 1'b1;
    next_s.wake = 1'b0;

    // status view; error flags belong to the word at the head
    status.rx_data_available_flag = !empty;
    status.receiver_idle_flag = (s.st == ST_IDLE) || (s.st == ST_WAITHI); // [RQ3] [RQ4]
    status.framing_error_flag = !empty && head.fe; // [RQ10]
    status.parity_error_flag = !empty && head.pe; // [RQ11]
    status.noise_flag = s.noise;
    status.overrun_flag = s.ovr;
    status.tx_empty = tx_buffer_empty_i;
    status.tx_idle = tx_idle_i;

    // bus slave: one wait cycle, effects on the completing edge
    if ((avs_read_i || avs_write_i) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = '0;
      if (avs_read_i) begin
        case (avs_address_i)
          REG_STATUS: next_s.rdata = DATA_W'(status);
          REG_CTRL: next_s.rdata = DATA_W'(s.ctrl);
          REG_DATA: next_s.rdata = DATA_W'(head.word);
          REG_COUNT: next_s.rdata = DATA_W'(count);
          REG_BAUD: next_s.rdata = DATA_W'(s.baud);
          default: next_s.rdata = '0;
        endcase
      end
    end else if (!s.waitreq) begin
      next_s.waitreq = 1'b1;
      if (avs_write_i) begin
        // status writes fall through with no effect
        case (avs_address_i)
          REG_CTRL: next_s.ctrl = urx_ctrl_t'(avs_writedata_i[CTRL_W-1:0]); // [RQ15]
          REG_BAUD: next_s.baud = avs_writedata_i[BAUD_W-1:0];
          default: ;
        endcase
      end else if (avs_read_i && (avs_address_i == REG_STATUS)) begin
        next_s.arm = 1'b1;
      end else if (avs_read_i && (avs_address_i == REG_DATA)) begin
        pop = 1'b1;
        next_s.arm = 1'b0;
        if (s.arm) begin
          next_s.noise = 1'b0; // [RQ9]
          next_s.ovr = 1'b0; // [RQ7]
        end
      end
    end

    // recovery after the clock returns
    next_s.off_prev = fh_off_i;
    if (s.off_prev && !fh_off_i) begin
      next_s.rec = RW'(RECOVER_CYCLES);
    end else if (s.rec != '0) begin
      next_s.rec = s.rec - 1'b1;
      if (s.wpend) begin
        next_s.st = ST_WAITHI; // [RQ21]
      end
      if (s.rec == RW'(1)) begin
        next_s.wpend = 1'b0;
        wake_irq = s.wpend && global_interrupt_enable_i && multifunction_interrupt_enable_i
                   && port_interrupt_enable_i; // [RQ21]
      end
    end

    // pin wake-up while the peripheral clock is off
    next_s.rx_prev = rx;
    if (fh_off_i && s.ctrl.rx_wake_enable && s.ctrl.port_enable && s.ctrl.receiver_enable
        && s.ctrl.rx_interrupt_enable && s.rx_prev && !rx) begin
      next_s.wake = 1'b1; // [RQ20]
      next_s.wpend = 1'b1;
    end

    // receiver holds everything while paused, and while recovering unless a pending wake moves it to ST_WAITHI
    running = !fh_off_i && (s.rec == '0) && s.ctrl.port_enable && s.ctrl.receiver_enable; // [RQ18]
    tick = (s.div == s.baud);
    if (running) begin
      next_s.div = tick ? '0 : s.div + 1'b1;
    end
    if (!(s.ctrl.port_enable && s.ctrl.receiver_enable)) begin
      next_s.st = ST_IDLE;
      next_s.div = '0;
    end

    // oversampled bit recovery
    votes = {s.smp[1:0], rx};
    bitv = vote3(votes); // [RQ22]
    mid = (s.os == SMP_C);
    if (running && tick) begin
      if ((s.os == SMP_A) || (s.os == SMP_B) || mid) begin
        next_s.smp = votes;
      end
      if ((s.st != ST_IDLE) && (s.st != ST_WAITHI)) begin
        next_s.os = s.os + 1'b1;
        if (mid && !(&votes || ~|votes)) begin
          next_s.nz_frame = 1'b1;
        end
      end
      unique case (s.st)
        ST_IDLE: begin
          if (!rx) begin
            next_s.st = ST_START;
            next_s.os = '0;
            next_s.nbit = '0;
            next_s.nz_frame = 1'b0;
          end
        end
        ST_START: begin
          if (mid && bitv) begin
            next_s.st = ST_IDLE;
          end else if (s.os == OS_LAST) begin
            next_s.st = ST_DATA;
          end
        end
        ST_DATA: begin
          if (mid) begin
            next_s.sh = {bitv, s.sh[WORD_W-1:1]};
            next_s.nbit = s.nbit + 1'b1;
          end
          if ((s.os == OS_LAST) && (s.nbit == (s.ctrl.nine_bit_select ? LEN_NINE : LEN_EIGHT))) begin
            next_s.st = ST_STOP1;
          end
        end
        ST_STOP1: begin
          if (mid) begin
            if (!bitv) begin
              fin = 1'b1; // [RQ1]
              fe_now = 1'b1; // [RQ10]
              next_s.st = ST_WAITHI; // [RQ2]
            end else if (!s.ctrl.two_stop) begin
              fin = 1'b1;
              next_s.st = ST_IDLE;
            end
          end else if (s.os == OS_LAST) begin
            next_s.st = ST_STOP2;
          end
        end
        ST_STOP2: begin
          if (mid) begin
            fin = 1'b1;
            fe_now = !bitv; // [RQ10]
            next_s.st = bitv ? ST_IDLE : ST_WAITHI; // [RQ2]
          end
        end
        ST_WAITHI: begin
          if (rx) begin
            next_s.st = ST_IDLE; // [RQ2]
          end
        end
      endcase
    end

    // word alignment and parity over the bits below the top bit
    w = s.ctrl.nine_bit_select ? s.sh : {1'b0, s.sh[WORD_W-1:1]};
    msb = s.ctrl.nine_bit_select ? w[8] : w[7];
    ones = s.ctrl.nine_bit_select ? ^w[7:0] : ^w[6:0];
    unique case (s.ctrl.parity_type)
      PAR_EVEN: pe = (msb != ones);
      PAR_ODD: pe = (msb == ones);
      PAR_MARK: pe = !msb;
      PAR_SPACE: pe = msb;
    endcase
    pe = pe && s.ctrl.parity_enable; // [RQ11]

    // transfer into the buffer or overrun, flags in the same cycle
    space = !full || pop;
    if (fin) begin
      if (space) begin
        push = 1'b1; // [RQ23]
        entry.word = w;
        entry.fe = fe_now;
        entry.pe = pe;
        if (s.nz_frame || (mid && !(&votes || ~|votes))) begin
          next_s.noise = 1'b1; // [RQ8]
        end
      end else begin
        next_s.ovr = 1'b1; // [RQ6]
      end
    end

    // interrupt sources and the active-low pulse
    rx_evt = fin && space && s.ctrl.rx_interrupt_enable
             && (s.ctrl.address_detect_enable ? msb : (count >= CW'(s.ctrl.trig_level))); // [RQ5] [RQ16]
    ovr_evt = fin && !space && s.ctrl.rx_interrupt_enable; // [RQ5] [RQ14]
    tx_lvl = {tx_idle_i && s.ctrl.tx_idle_ie, tx_buffer_empty_i && s.ctrl.tx_empty_ie}; // [RQ14]
    next_s.tx_prev = tx_lvl;
    tx_evt = |(tx_lvl & ~s.tx_prev);
    next_s.irq_n = !(rx_evt || ovr_evt || tx_evt || wake_irq); // [RQ13]
  end

  // state register; sync reset to defined values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.baud <= BAUD_RESET;
      s.waitreq <= 1'b1;
      s.irq_n <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.waitreq;
  assign irq_n_o = s.irq_n;
  assign wake_o = s.wake;
endmodule

// File: verif/urx_line_model.sv
// remote serial transmitter driving the receive pin, 16 clocks a bit
// assumes baud register 0 in the block and send_i pulsed for one clock
`timescale 1ns/1ps
module urx_line_model (
  // clock
  input wire logic clk_i,
  // frame request
  input wire logic send_i,
  input wire logic [19:0] frame_i,
  input wire logic [4:0] glitch_i,
  // line
  output logic line_o,
  output logic busy_o = 1'b0
);
  logic [19:0] sh;
  logic [4:0] bit_n;
  logic [4:0] gl;
  logic [3:0] sub;
  // twenty bit slots, start bit first, lsb first
  always @(posedge clk_i) begin
    if (send_i) begin
      sh <= frame_i;
      bit_n <= 5'h00;
      gl <= glitch_i;
      sub <= 4'h0;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      sub <= sub + 4'h1;
      if (sub == 4'hf) begin
        sh <= sh >> 1;
        bit_n <= bit_n + 5'h01;
        busy_o <= (bit_n != 5'h13);
      end
    end
  end
  // idle high; a one-clock flip mid-bit disturbs one vote only
  assign line_o = !busy_o || (sh[0] ^ (bit_n == gl && sub == 4'h8));
endmodule

// File: verif/urx_chk_chk.sv
// concurrent checks on the ports of the receive block
// assumes one clock domain and a bind from the bench top file
`timescale 1ns/1ps
module urx_chk
  import urx_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int RECOVER_CYCLES = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [urx_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [urx_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // system and requests
  input wire logic fh_off_i,
  input wire logic irq_n_o,
  input wire logic wake_o
);
  logic [7:0] rec;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles left of the recovery span after the clock returns
  always_ff @(posedge clk_i) begin
    if (rst_i) rec <= 8'h00;
    else if ($fell(fh_off_i)) rec <= 8'(RECOVER_CYCLES - 1);
    else if (rec != 8'h00) rec <= rec - 8'h01;
  end
  irq_pulse_a: assert property (!irq_n_o |=> irq_n_o)
    else $error("interrupt request low for more than one cycle");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  wake_off_a: assert property (wake_o |-> $past(fh_off_i, 3))
    else $error("wake without clock off");
  quiet_off_a: assert property (fh_off_i && $past(fh_off_i) |-> irq_n_o)
    else $error("interrupt while clock off");
  recover_a: assert property (!irq_n_o |-> rec == 8'h00)
    else $error("interrupt inside recovery span");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  unmapped_zero_a: assert property (!avs_waitrequest_o && $past(avs_read_i) && $past(avs_address_i) > REG_BAUD
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  status_top_a: assert property (!avs_waitrequest_o && $past(avs_read_i) && $past(avs_address_i) == REG_STATUS
    |-> avs_readdata_o[31:8] == 24'h0)
    else $error("status upper bits set");
  cover property (!irq_n_o);
  cover property (wake_o);
  cover property ($fell(fh_off_i) ##[1:40] !irq_n_o);
endmodule

// File: verif/tb.sv
// self-checking bench for the receive block with a line model on the pin
// assumes baud register 0 (bit = 16 clocks) and a short recovery span
`timescale 1ns/1ps
module tb;
  import urx_pkg::*;
  typedef struct packed {
    logic [15:0] ctl;
    logic [8:0] d;
    logic [1:0] st;
    logic [8:0] w;
    logic [5:0] s;
  } urx_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] av_a = '0;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rdata;
  logic waitreq, irq_n, wake, line, busy;
  logic fh = 1'b0;
  logic pe = 1'b1;
  logic te = 1'b0;
  logic ti = 1'b0;
  logic snd = 1'b0;
  logic [19:0] fr = 20'hfffff;
  logic [4:0] gl = 5'h1f;
  int fail_count = 0;
  int checks_done = 0;
  int irqs = 0;
  int wakes = 0;
  int n0, w0;
  urx_row_t rows[9] = '{
    '{16'h0083, 9'h0a5, 2'b11, 9'h0a5, 6'h03}, '{16'h008b, 9'h003, 2'b11, 9'h003, 6'h03},
    '{16'h008b, 9'h083, 2'b11, 9'h083, 6'h0b}, '{16'h009b, 9'h083, 2'b11, 9'h083, 6'h03},
    '{16'h00ab, 9'h001, 2'b11, 9'h001, 6'h0b}, '{16'h00bb, 9'h001, 2'b11, 9'h001, 6'h03},
    '{16'h0087, 9'h1a5, 2'b11, 9'h1a5, 6'h03}, '{16'h00c3, 9'h05a, 2'b01, 9'h05a, 6'h07},
    '{16'h0083, 9'h05a, 2'b10, 9'h05a, 6'h07}};
  // device and line model
  urx_top #(.FIFO_DEPTH(4), .RECOVER_CYCLES(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(av_a), .avs_read_i(av_r), .avs_write_i(av_w), .avs_writedata_i(av_d),
    .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq), .serial_receive_pin_i(line), .fh_off_i(fh),
    .global_interrupt_enable_i(1'b1), .multifunction_interrupt_enable_i(1'b1), .port_interrupt_enable_i(pe),
    .tx_buffer_empty_i(te), .tx_idle_i(ti), .irq_n_o(irq_n), .wake_o(wake));
  urx_line_model u_line (.clk_i(clk_i), .send_i(snd), .frame_i(fr), .glitch_i(gl), .line_o(line),
    .busy_o(busy));
  // clock and pulse counters
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (irq_n === 1'b0) irqs++;
    if (wake === 1'b1) wakes++;
  end
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    av_a <= a;
    av_d <= d;
    av_w <= w;
    av_r <= !w;
    do begin
      @(posedge clk_i);
    end while (waitreq !== 1'b0);
    rdata = readdata;
    av_w <= 1'b0;
    av_r <= 1'b0;
  endtask
  task automatic go(input logic [19:0] f, input logic [4:0] g);
    @(posedge clk_i);
    snd <= 1'b1;
    fr <= f;
    gl <= g;
    @(posedge clk_i);
    snd <= 1'b0;
  endtask
  task automatic frame(input logic [19:0] f);
    go(f, 5'h1f);
    repeat (330) @(posedge clk_i);
  endtask
  function automatic logic [19:0] mkf(input logic [8:0] d, input logic nine, input logic [1:0] st);
    return nine ? {8'hff, st, d, 1'b0} : {9'h1ff, st, d[7:0], 1'b0};
  endfunction
  // watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, REG_STATUS, 0); chk(rdata, 32'h02);
    bus(0, REG_CTRL, 0); chk(rdata, 32'h0);
    bus(0, REG_BAUD, 0); chk(rdata, 32'h0);
    bus(0, 5'h14, 0); chk(rdata, 32'h0);
    // baud written while the receiver is off, so the divider stays cleared
    bus(1, REG_BAUD, 32'h12345);
    bus(0, REG_BAUD, 0); chk(rdata, 32'h2345);
    bus(1, REG_BAUD, 32'h0);
    bus(1, REG_CTRL, 32'h3fff);
    bus(0, REG_CTRL, 0); chk(rdata, 32'h3fff);
    foreach (rows[i]) begin
      bus(1, REG_CTRL, {16'h0, rows[i].ctl});
      n0 = irqs;
      frame(mkf(rows[i].d, rows[i].ctl[2], rows[i].st));
      chk(irqs - n0, 1);
      bus(0, REG_STATUS, 0); chk(rdata, {26'h0, rows[i].s});
      bus(0, REG_DATA, 0); chk(rdata, {23'h0, rows[i].w});
    end
    // noise on one vote, idle flag mid-frame
    n0 = irqs;
    go(mkf(9'h055, 1'b0, 2'b11), 5'd3);
    repeat (80) @(posedge clk_i);
    bus(0, REG_STATUS, 0); chk(rdata, 32'h00);
    repeat (250) @(posedge clk_i);
    chk(irqs - n0, 1);
    bus(0, REG_STATUS, 0); chk(rdata, 32'h13);
    bus(0, REG_DATA, 0); chk(rdata, 32'h55);
    bus(0, REG_STATUS, 0); chk(rdata, 32'h02);
    // long break, line still low when checked
    n0 = irqs;
    go(20'h0, 5'h1f);
    repeat (200) @(posedge clk_i);
    chk(irqs - n0, 1);
    bus(0, REG_STATUS, 0); chk(rdata, 32'h07);
    bus(0, REG_DATA, 0); chk(rdata, 32'h0);
    repeat (200) @(posedge clk_i);
    bus(0, REG_COUNT, 0); chk(rdata, 32'h0);
    frame(mkf(9'h03c, 1'b0, 2'b11));
    bus(0, REG_DATA, 0); chk(rdata, 32'h3c);
    // five frames into four places
    n0 = irqs;
    for (int k = 0; k < 5; k++) frame(mkf(9'h010 + 9'(k), 1'b0, 2'b11));
    chk(irqs - n0, 5);
    bus(1, REG_STATUS, 32'h0);
    bus(0, REG_COUNT, 0); chk(rdata, 32'h4);
    bus(0, REG_DATA, 0); chk(rdata, 32'h10);
    bus(0, REG_STATUS, 0); chk(rdata, 32'h23);
    bus(0, REG_DATA, 0); chk(rdata, 32'h11);
    bus(0, REG_STATUS, 0); chk(rdata, 32'h03);
    bus(0, REG_DATA, 0); chk(rdata, 32'h12);
    bus(0, REG_DATA, 0); chk(rdata, 32'h13);
    // address detect in both word lengths, then no enable
    n0 = irqs;
    bus(1, REG_CTRL, 32'h183);
    frame(mkf(9'h012, 1'b0, 2'b11));
    frame(mkf(9'h092, 1'b0, 2'b11));
    bus(1, REG_CTRL, 32'h187);
    frame(mkf(9'h080, 1'b1, 2'b11));
    frame(mkf(9'h100, 1'b1, 2'b11));
    chk(irqs - n0, 2);
    repeat (4) bus(0, REG_DATA, 0);
    bus(1, REG_CTRL, 32'h03);
    n0 = irqs;
    frame(mkf(9'h033, 1'b0, 2'b11));
    chk(irqs - n0, 0);
    bus(0, REG_DATA, 0);
    // wake from clock off, with and without port interrupt enable
    bus(1, REG_CTRL, 32'h283);
    for (int k = 0; k < 2; k++) begin
      pe <= (k == 0);
      fh <= 1'b1;
      n0 = irqs;
      w0 = wakes;
      go(mkf(9'h0ff, 1'b0, 2'b11), 5'h1f);
      repeat (20) @(posedge clk_i);
      chk(irqs - n0, 0);
      fh <= 1'b0;
      repeat (330) @(posedge clk_i);
      chk(wakes - w0, 1);
      chk(irqs - n0, (k == 0) ? 1 : 0);
      bus(0, REG_COUNT, 0); chk(rdata, 32'h0);
    end
    // transmitter sources, each behind its own enable
    bus(1, REG_CTRL, 32'h403);
    n0 = irqs;
    te <= 1'b1;
    ti <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(irqs - n0, 1);
    bus(0, REG_STATUS, 0); chk(rdata, 32'hc2);
    te <= 1'b0;
    ti <= 1'b0;
    bus(1, REG_CTRL, 32'h803);
    ti <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(irqs - n0, 2);
    ti <= 1'b0;
    // stored error cleared by reset
    frame(mkf(9'h05a, 1'b0, 2'b10));
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, REG_STATUS, 0); chk(rdata, 32'h02);
    end_sim();
  end
endmodule
bind urx_top urx_chk #(.FIFO_DEPTH(FIFO_DEPTH), .RECOVER_CYCLES(RECOVER_CYCLES)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .fh_off_i(fh_off_i),
  .irq_n_o(irq_n_o), .wake_o(wake_o));
